// File: design/ubr_pkg.sv
// ubr_pkg: shared constants and types for the backup relay / restart controller
// assumes one 250 MHz clock; all sequencer timers count a 1 ms tick
package ubr_pkg;

   // timing
   localparam int CLK_HZ       = 250_000_000;
   localparam int TICK_MS      = 1;
   localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
   localparam int BLINK_MS     = 500;   // half period of the 1 Hz toggle

   // widths
   localparam int TW = 20;              // timer width in bits; timer values count ms
   localparam int AW = 12;              // analog measurement width
   localparam int PW = 8;               // percentage width

   // relay event selector codes
   localparam logic [3:0] EV_NONE     = 4'h0;
   localparam logic [3:0] EV_BACKUP   = 4'h1;
   localparam logic [3:0] EV_LOWBATT  = 4'h2;
   localparam logic [3:0] EV_LIFE     = 4'h3;
   localparam logic [3:0] EV_HIGHRES  = 4'h4;
   localparam logic [3:0] EV_BATTFAIL = 4'h5;
   localparam logic [3:0] EV_UNDERV   = 4'h6;
   localparam logic [3:0] EV_TIMELEFT = 4'h7;
   localparam logic [3:0] EV_PCOFF    = 4'h8;

   // factory defaults: relay 1 ready (lifetime event only), relay 2 backup
   localparam logic [3:0] RELAY1_EV_RESET = EV_LIFE;
   localparam logic [3:0] RELAY2_EV_RESET = EV_BACKUP;
   localparam logic       POL_NC          = 1'b1;

   // thresholds in percent
   localparam logic [PW-1:0] LOW_SOC_PCT   = 8'h19;   // 25
   localparam logic [PW-1:0] BLINK_SOC_PCT = 8'h14;   // 20

   // relay configuration carrier
   typedef struct packed {
      logic [3:0] event_sel;
      logic       nc_polarity;
   } ubr_relay_cfg_t;

   // sequencer timer settings, in ms
   typedef struct packed {
      logic [TW-1:0] shutdown_delay_time;
      logic [TW-1:0] shutdown_duration_time;
      logic [TW-1:0] restart_min_off_time;
      logic [TW-1:0] off_detect_time;
      logic [TW-1:0] max_backup_time;
   } ubr_timers_t;

   // battery measurements and limits
   typedef struct packed {
      logic [PW-1:0] soc_pct;
      logic [AW-1:0] batt_voltage;
      logic [AW-1:0] deep_discharge_voltage;
      logic [AW-1:0] battery_internal_resistance;
      logic [AW-1:0] nominal_resistance;
      logic [AW-1:0] max_resistance_variation;
      logic [31:0]   batt_operating_time;
      logic [31:0]   batt_lifetime;
      logic          charge_failed;
   } ubr_batt_t;

   typedef enum logic [2:0] {
      ST_NORMAL   = 3'b000,
      ST_BACKUP   = 3'b001,
      ST_SHUTDOWN = 3'b011,
      ST_OFF      = 3'b010,
      ST_MINOFF   = 3'b110
   } ubr_state_t;

endpackage : ubr_pkg

// File: design/ubr_ctrl.sv
// ubr_ctrl: backup switch, relay event mapping and PC shutdown/restart sequencer
// assumes pin-level inputs are asynchronous; settings and measurements are stable
// values from logic on mclk
//
// Functional notes
// RQ1: two relays, each selectable event and polarity
// RQ2: backup event while load on battery
// RQ3: low-battery event while charge below 25%
// RQ4: lifetime event once operating time exceeds lifetime
// RQ5: high-resistance event above nominal plus variation
// RQ6: battery-failure event when charging failed
// RQ7: under-voltage event below deep-discharge voltage
// RQ8: time-left event past 75% of max backup
// RQ9: PC-off event driven only by sequencer
// RQ10: both relays normally-closed after reset
// RQ11: input loss connects battery to load immediately
// RQ12: indicate backup; watch battery against deep discharge
// RQ13: backup timer ends battery supply at maximum
// RQ14: ready relay toggles 1 Hz below 20%
// RQ15: inhibit input blocks backup, selectable polarity
// RQ16: shutdown request on delay or battery low
// RQ17: output off after shutdown duration time
// RQ18: input return waits minimum-off before output on
// RQ19: low current for off-detect time restarts PC
// RQ20: restart off time equals minimum-off time
// RQ21: PC-off relay in series breaks input path
// RQ22: host shuts down OS on request
// RQ23: 1 ms tick timers; reset to normal supply
module ubr_ctrl #(
   parameter int TICK_CYCLES = ubr_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic                 mclk,
   input  wire logic                 reset,
   // pins
   input  wire logic                 inputPresent,
   input  wire logic                 inhibitPin,
   // settings
   input  wire logic                 inhibitActiveHigh,
   input  wire logic                 shutdownEnable,
   input  wire ubr_pkg::ubr_relay_cfg_t relay1Cfg,
   input  wire ubr_pkg::ubr_relay_cfg_t relay2Cfg,
   input  wire ubr_pkg::ubr_timers_t timers,
   input  wire logic [ubr_pkg::AW-1:0] offCurrentThreshold,
   // measurements
   input  wire logic [ubr_pkg::AW-1:0] outputCurrent,
   input  wire ubr_pkg::ubr_batt_t   batt,
   // outputs
   output logic                      batterySwitch,
   output logic                      outputEnable,
   output logic                      backupActive,
   output logic                      shutdownRequest,
   output logic                      relay1,
   output logic                      relay2,
   output logic [8:0]                events
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [1:0] inSync;
   logic [1:0] inhSync;
   always_ff @(posedge mclk) begin
      inSync  <= {inSync[0], inputPresent};
      inhSync <= {inhSync[0], inhibitPin};
   end
   wire logic inOk      = inSync[1];
   wire logic inhibited = (inhSync[1] == inhibitActiveHigh);   // [RQ15]

   ////////////////////////////////////////////////////////////////////////////
   // 1 ms tick
   logic [$clog2(TICK_CYCLES)-1:0] prescale;
   wire logic tick = (prescale == $bits(prescale)'(TICK_CYCLES - 1));
   always_ff @(posedge mclk) begin
      if (reset || tick) begin
         prescale <= '0;
      end else begin
         prescale <= prescale + 1'b1;
      end
   end   // [RQ23]

   ////////////////////////////////////////////////////////////////////////////
   // battery events
   wire logic evLowBatt  = (batt.soc_pct < ubr_pkg::LOW_SOC_PCT);                 // [RQ3]
   wire logic evLife     = (batt.batt_operating_time > batt.batt_lifetime);       // [RQ4]
   wire logic [ubr_pkg::AW:0] riLimit = {1'b0, batt.nominal_resistance}
                                      + {1'b0, batt.max_resistance_variation};
   wire logic evHighRes  = ({1'b0, batt.battery_internal_resistance} > riLimit);  // [RQ5]
   wire logic evBattFail = batt.charge_failed;                                    // [RQ6]
   wire logic evUnderV   = (batt.batt_voltage < batt.deep_discharge_voltage);     // [RQ7]

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   ubr_pkg::ubr_state_t state;
   ubr_pkg::ubr_state_t next_state;
   logic [ubr_pkg::TW-1:0] backupMs;    // time since start of backup
   logic [ubr_pkg::TW-1:0] phaseMs;     // time in current phase
   logic [ubr_pkg::TW-1:0] lowCurMs;    // time output current stayed low
   logic                   pcOff;

   wire logic [ubr_pkg::TW+1:0] maxBackup4 = {2'b00, timers.max_backup_time};
   wire logic [ubr_pkg::TW+1:0] elapsed4   = {backupMs, 2'b00};
   // 3/4 threshold done in x4 space to avoid truncation
   wire logic [ubr_pkg::TW+1:0] maxBackup3 = maxBackup4 + (maxBackup4 << 1);
   wire logic evTimeLeft = (state != ubr_pkg::ST_NORMAL) &&
                           (elapsed4 > maxBackup3);                               // [RQ8]
   wire logic backupEnd  = (backupMs >= timers.max_backup_time);                  // [RQ13]
   wire logic lowCurrent = (outputCurrent < offCurrentThreshold);
   wire logic offDetect  = (lowCurMs >= timers.off_detect_time);                  // [RQ19]

   always_comb begin
      next_state = state;
      unique case (state)
         ubr_pkg::ST_NORMAL: begin
            if (!inOk && !inhibited) begin
               next_state = ubr_pkg::ST_BACKUP;                                   // [RQ11]
            end else if (inOk && shutdownEnable && offDetect) begin
               next_state = ubr_pkg::ST_MINOFF;                                   // [RQ19]
            end
         end
         ubr_pkg::ST_BACKUP: begin
            if (inOk) begin
               next_state = ubr_pkg::ST_NORMAL;
            end else if (inhibited || evUnderV || backupEnd) begin
               next_state = ubr_pkg::ST_OFF;                                      // [RQ12] [RQ13]
            end else if (shutdownEnable &&
                         (backupMs >= timers.shutdown_delay_time || evLowBatt)) begin
               next_state = ubr_pkg::ST_SHUTDOWN;                                 // [RQ16]
            end
         end
         ubr_pkg::ST_SHUTDOWN: begin
            if (phaseMs >= timers.shutdown_duration_time || inhibited || evUnderV ||
                backupEnd) begin
               next_state = ubr_pkg::ST_OFF;                                      // [RQ17]
            end
         end
         ubr_pkg::ST_OFF: begin
            if (inOk) begin
               next_state = ubr_pkg::ST_MINOFF;                                   // [RQ18]
            end
         end
         ubr_pkg::ST_MINOFF: begin
            if (!inOk) begin
               next_state = ubr_pkg::ST_OFF;
            end else if (phaseMs >= timers.restart_min_off_time) begin
               next_state = ubr_pkg::ST_NORMAL;                                   // [RQ18] [RQ20]
            end
         end
         default: next_state = ubr_pkg::ST_NORMAL;
      endcase
   end

   wire logic stateChange = (next_state != state);

   always_ff @(posedge mclk) begin
      if (reset) begin
         state    <= ubr_pkg::ST_NORMAL;                                          // [RQ23]
         backupMs <= '0;
         phaseMs  <= '0;
         lowCurMs <= '0;
      end else begin
         state    <= next_state;
         if (state == ubr_pkg::ST_NORMAL || state == ubr_pkg::ST_MINOFF) begin
            backupMs <= '0;
         end else if (tick && !(&backupMs)) begin
            backupMs <= backupMs + 1'b1;
         end
         if (stateChange) begin
            phaseMs <= '0;
         end else if (tick && !(&phaseMs)) begin
            phaseMs <= phaseMs + 1'b1;
         end
         // restarts count only in the normal supply state, whether or not the input is present
         if (!lowCurrent || state != ubr_pkg::ST_NORMAL) begin
            lowCurMs <= '0;
         end else if (tick && !(&lowCurMs)) begin
            lowCurMs <= lowCurMs + 1'b1;
         end
      end
   end

   // pc-off holds the series relay open while output is down
   wire logic next_pcOff = (next_state == ubr_pkg::ST_OFF) ||
                           (next_state == ubr_pkg::ST_MINOFF);                    // [RQ9] [RQ21]

   ////////////////////////////////////////////////////////////////////////////
   // 1 Hz blink for ready relay
   logic [$clog2(ubr_pkg::BLINK_MS)-1:0] blinkMs;
   logic blink;
   wire logic blinkWrap = tick && (blinkMs == $bits(blinkMs)'(ubr_pkg::BLINK_MS - 1));
   always_ff @(posedge mclk) begin
      if (reset || state != ubr_pkg::ST_BACKUP && state != ubr_pkg::ST_SHUTDOWN) begin
         blinkMs <= '0;
         blink   <= 1'b0;
      end else if (blinkWrap) begin
         blinkMs <= '0;
         blink   <= ~blink;                                                       // [RQ14]
      end else if (tick) begin
         blinkMs <= blinkMs + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // relay mapping
   wire logic onBattery = (state == ubr_pkg::ST_BACKUP) || (state == ubr_pkg::ST_SHUTDOWN);
   wire logic [8:0] next_events = {pcOff, evTimeLeft, evUnderV, evBattFail, evHighRes,
                                   evLife, evLowBatt, onBattery, 1'b0};           // [RQ2]

   function automatic logic relay_drive(input ubr_pkg::ubr_relay_cfg_t cfg,
                                        input logic [8:0] ev);
      logic act;
      act = (cfg.event_sel <= ubr_pkg::EV_PCOFF) ? ev[cfg.event_sel] : 1'b0;
      // nc: coil energised while idle, drops on event
      relay_drive = cfg.nc_polarity ? ~act : act;
   endfunction : relay_drive

   // ready relay (relay 1) blinks when charge is low during backup
   wire logic blinkLow = onBattery && (batt.soc_pct < ubr_pkg::BLINK_SOC_PCT);
   wire logic next_relay1 = blinkLow ? blink : relay_drive(relay1Cfg, next_events); // [RQ14]
   wire logic next_relay2 = relay_drive(relay2Cfg, next_events);                  // [RQ1]

   always_ff @(posedge mclk) begin
      if (reset) begin
         batterySwitch   <= 1'b0;
         outputEnable    <= 1'b1;                                                 // [RQ23]
         backupActive    <= 1'b0;
         shutdownRequest <= 1'b0;
         pcOff           <= 1'b0;
         relay1          <= ubr_pkg::POL_NC;                                      // [RQ10]
         relay2          <= ubr_pkg::POL_NC;                                      // [RQ10]
         events          <= '0;
      end else begin
         batterySwitch   <= onBattery;                                            // [RQ11]
         outputEnable    <= !next_pcOff;
         backupActive    <= onBattery;                                            // [RQ12]
         shutdownRequest <= (state == ubr_pkg::ST_SHUTDOWN);                      // [RQ16]
         pcOff           <= next_pcOff;                                           // [RQ9]
         relay1          <= next_relay1;                                          // [RQ1]
         relay2          <= next_relay2;                                          // [RQ1]
         events          <= next_events;
      end
   end

endmodule : ubr_ctrl

// File: verif/ubr_ctrl_assertions.sv
// ubr_ctrl_assertions: port-level checks of the backup relay / restart controller
// assumes bind into ubr_ctrl; one clock domain, synchronous active-high reset
module ubr_ctrl_assertions (
   // clock and reset
   input wire logic                    mclk,
   input wire logic                    reset,
   // watched inputs
   input wire logic                    inputPresent,
   input wire logic                    inhibitPin,
   input wire logic                    inhibitActiveHigh,
   input wire logic                    shutdownEnable,
   input wire ubr_pkg::ubr_relay_cfg_t relay2Cfg,
   input wire ubr_pkg::ubr_batt_t      batt,
   // watched outputs
   input wire logic                    batterySwitch,
   input wire logic                    outputEnable,
   input wire logic                    backupActive,
   input wire logic                    shutdownRequest,
   input wire logic                    relay2,
   input wire logic [8:0]              events
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   wire inh = (inhibitPin == inhibitActiveHigh);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_drop;
      $fell(inputPresent) && !inh && outputEnable && !batterySwitch;
   endsequence
   sequence s_held;
      (!inputPresent && !inh) [*4];
   endsequence
   property p_outage; s_drop ##1 s_held |-> batterySwitch; endproperty
   property p_rst; $fell(reset) |-> outputEnable && !batterySwitch && !shutdownRequest; endproperty
   property p_flag; backupActive == batterySwitch; endproperty
   property p_shut_batt; shutdownRequest |-> batterySwitch; endproperty
   property p_shut_en; $rose(shutdownRequest) |-> shutdownEnable; endproperty
   // first edge after reset still shows reset-time events
   property p_soc;
      !$past(reset) && $stable(batt) |-> events[2] == (batt.soc_pct < ubr_pkg::LOW_SOC_PCT);
   endproperty
   property p_fail; !$past(reset) && $stable(batt) |-> events[5] == batt.charge_failed; endproperty
   property p_rly2;
      !$past(reset) && $stable(relay2Cfg) && relay2Cfg.event_sel == ubr_pkg::EV_BACKUP
         |-> relay2 == (relay2Cfg.nc_polarity ^ events[1]);
   endproperty
   a_outage: assert property (p_outage) else $error("battery not switched in");
   a_rst: assert property (p_rst) else $error("bad state after reset");
   a_flag: assert property (p_flag) else $error("backup flag off switch");
   a_shut_batt: assert property (p_shut_batt) else $error("request off battery");
   a_shut_en: assert property (p_shut_en) else $error("request while disabled");
   a_soc: assert property (p_soc) else $error("low charge event wrong");
   a_fail: assert property (p_fail) else $error("charge failure event wrong");
   a_rly2: assert property (p_rly2) else $error("relay 2 mapping wrong");
endmodule : ubr_ctrl_assertions
bind ubr_ctrl ubr_ctrl_assertions i_chk (.mclk, .reset, .inputPresent, .inhibitPin,
   .inhibitActiveHigh, .shutdownEnable, .relay2Cfg, .batt, .batterySwitch, .outputEnable,
   .backupActive, .shutdownRequest, .relay2, .events);

// File: verif/ubr_host_pc.sv
// ubr_host_pc: behavioural host PC fed from the controller output
// assumes the host boots whenever supply returns after having been removed
module ubr_host_pc #(
   parameter int SHUT_CYCLES = 15
) (
   input  wire logic                  mclk,
   input  wire logic                  outputEnable,
   input  wire logic                  shutdownRequest,
   input  wire logic                  crash,
   output logic [ubr_pkg::AW-1:0]     outputCurrent
);
   timeunit 1ns;
   timeprecision 1ps;
   int   shutCount = 0;
   logic halted    = 1'b0;
   always @(posedge mclk) begin
      if (!outputEnable) begin
         halted <= 1'b0;
         shutCount <= 0;
      end else if (crash) begin
         halted <= 1'b1;
      end else if (shutdownRequest) begin
         // OS shutdown takes a while, then the host stops drawing
         shutCount <= shutCount + 1;
         if (shutCount >= SHUT_CYCLES)
            halted <= 1'b1;
      end
   end
   // a halted host still leaks a little, below any sane threshold
   assign outputCurrent = (outputEnable && !halted) ? 12'h800 : 12'h010;
endmodule : ubr_host_pc

// File: verif/ubr_ctrl_bench.sv
// ubr_ctrl_bench: self-checking bench for the controller with a host PC model
// assumes a 1 ms tick shortened to TK cycles
module ubr_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 10;
   `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
      $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
   typedef struct packed { logic [3:0] sel; logic [8:0] exp; } ubr_note_t;
   logic mclk = 1'b0, reset = 1'b1, inputPresent = 1'b1, inhibitPin = 1'b0;
   logic inhibitActiveHigh = 1'b1, shutdownEnable = 1'b1, crash = 1'b0;
   logic batterySwitch, outputEnable, backupActive, shutdownRequest, relay1, relay2;
   logic [8:0]  events;
   logic [11:0] outputCurrent, offCurrentThreshold = 12'h100;
   ubr_pkg::ubr_relay_cfg_t relay1Cfg = {ubr_pkg::EV_LIFE, 1'b1};
   ubr_pkg::ubr_relay_cfg_t relay2Cfg = {ubr_pkg::EV_BACKUP, 1'b1};
   ubr_pkg::ubr_timers_t timers = {20'h3, 20'h4, 20'h2, 20'h5, 20'h32};
   ubr_pkg::ubr_batt_t batt = '0, safe;
   ubr_note_t q[$];
   event go;
   int n_mismatch = 0, comparisons = 0, seed = 25455, c;
   logic [8:0] e;
   logic pol, ev;
   always #2 mclk = ~mclk;
   ubr_ctrl #(.TICK_CYCLES(TK)) i_ubr_ctrl (.mclk, .reset, .inputPresent, .inhibitPin,
      .inhibitActiveHigh, .shutdownEnable, .relay1Cfg, .relay2Cfg, .timers,
      .offCurrentThreshold, .outputCurrent, .batt, .batterySwitch, .outputEnable,
      .backupActive, .shutdownRequest, .relay1, .relay2, .events);
   ubr_host_pc i_ubr_host_pc (.mclk, .outputEnable, .shutdownRequest, .crash, .outputCurrent);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [8:0] act(input logic [3:0] s);
      case (s)
         4'h0: act = {8'h00, batterySwitch};
         4'h1: act = {8'h00, outputEnable};
         4'h2: act = {8'h00, shutdownRequest};
         4'h3: act = {8'h00, relay1};
         4'h4: act = {8'h00, relay2};
         4'h5: act = events;
         default: act = 9'h001;
      endcase
   endfunction : act
   task note(input logic [3:0] s, input logic [8:0] x);
      q.push_back({s, x});
      ->go;
   endtask : note
   task cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   // bounded wait; c returns the cycles spent
   task waitFor(input logic [3:0] s, input logic [8:0] v);
      c = 0;
      while (act(s) !== v) begin
         cyc(1);
         c++;
         if (c > 2000) begin
            n_mismatch++;
            final_report();
         end
      end
   endtask : waitFor
   task span(input int lo, input int hi);
      note(4'h6, {8'h00, c >= lo && c <= hi});
   endtask : span
   task final_report;
      if (n_mismatch == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   always @(go) begin
      while (q.size() > 0) begin
         automatic ubr_note_t n = q.pop_front();
         `CHK(act(n.sel), n.exp)
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      safe = {8'h50, 12'hC00, 12'h400, 12'h000, 12'h100, 12'h000, 32'h0, 32'h1, 1'b0};
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      cyc(3);
      note(4'h1, 9'h001);
      note(4'h3, 9'h001);
      note(4'h4, 9'h001);
      for (int k = 0; k < 10; k++) begin
         @(posedge mclk);
         batt.soc_pct <= 8'($unsigned($random(seed)) % 50);
         batt.batt_voltage <= 12'($random(seed));
         batt.deep_discharge_voltage <= 12'($random(seed));
         batt.battery_internal_resistance <= 12'($random(seed));
         batt.nominal_resistance <= 12'($random(seed)) & 12'h7FF;
         batt.max_resistance_variation <= 12'($random(seed)) & 12'h7FF;
         batt.batt_operating_time <= $random(seed);
         batt.batt_lifetime <= $random(seed);
         batt.charge_failed <= 1'($random(seed));
         pol = 1'($random(seed));
         relay1Cfg <= {4'(k), pol};
         cyc(3);
         e = 9'h000;
         e[2] = batt.soc_pct < ubr_pkg::LOW_SOC_PCT;
         e[3] = batt.batt_operating_time > batt.batt_lifetime;
         e[4] = batt.battery_internal_resistance
            > batt.nominal_resistance + batt.max_resistance_variation;
         e[5] = batt.charge_failed;
         e[6] = batt.batt_voltage < batt.deep_discharge_voltage;
         ev = (k <= 8) ? e[k] : 1'b0;
         note(4'h5, e);
         note(4'h3, {8'h00, pol ^ ev});
      end
      // second outage runs on a nearly empty battery
      for (int r = 0; r < 2; r++) begin
         @(posedge mclk);
         batt <= safe;
         batt.soc_pct <= (r == 0) ? 8'h50 : 8'h10;
         relay1Cfg <= {ubr_pkg::EV_LIFE, 1'b1};
         cyc(40);
         @(posedge mclk);
         inputPresent <= 1'b0;
         cyc(5);
         note(4'h0, 9'h001);
         note(4'h4, 9'h000);
         waitFor(4'h2, 9'h001);
         if (r == 0)
            span(3 * TK - 9, 3 * TK + 2);
         else
            span(0, TK);
         waitFor(4'h1, 9'h000);
         span(3 * TK + 1, 4 * TK);
         @(posedge mclk);
         inputPresent <= 1'b1;
         waitFor(4'h1, 9'h001);
         span(TK + 4, 2 * TK + 4);
      end
      cyc(20);
      @(posedge mclk);
      crash <= 1'b1;
      @(posedge mclk);
      crash <= 1'b0;
      waitFor(4'h1, 9'h000);
      span(4 * TK + 2, 5 * TK + 2);
      waitFor(4'h1, 9'h001);
      span(TK + 2, 2 * TK + 2);
      @(posedge mclk);
      inhibitPin <= 1'b1;
      cyc(4);
      @(posedge mclk);
      inputPresent <= 1'b0;
      cyc(10);
      note(4'h0, 9'h000);
      cyc(2);
      final_report();
   end
endmodule : ubr_ctrl_bench
